// >>> acs_pkg.sv
// Package: register map, field positions, reset values and limits for the record control block
package acs_pkg;
    // Printed offsets are register indices; byte address is four times the index
    localparam logic [7:0]  COEF_CTRL_IDX       = 8'h01;
    localparam logic [7:0]  DCM_CTRL_IDX        = 8'h67;
    localparam logic [7:0]  RUN_CTRL_IDX        = 8'h10;
    localparam logic [7:0]  DIV_CTRL_IDX        = 8'h11;
    localparam logic [7:0]  DCM_LEN_IDX         = 8'h12;
    localparam logic [11:0] COEF_CTRL_ADDR      = {2'h0, COEF_CTRL_IDX, 2'h0};
    localparam logic [11:0] DCM_CTRL_ADDR       = {2'h0, DCM_CTRL_IDX, 2'h0};
    localparam logic [11:0] RUN_CTRL_ADDR       = {2'h0, RUN_CTRL_IDX, 2'h0};
    localparam logic [11:0] DIV_CTRL_ADDR       = {2'h0, DIV_CTRL_IDX, 2'h0};
    localparam logic [11:0] DCM_LEN_ADDR        = {2'h0, DCM_LEN_IDX, 2'h0};
    localparam logic [11:0] COEF_BASE_ADDR      = 12'h800;
    localparam int          COEF_SWAP_BIT       = 0;
    localparam int          COEF_INUSE_BIT      = 1;
    localparam int          COEF_ADAPT_BIT      = 2;
    localparam int          COEF_SEL_BIT        = 3;
    localparam int          DCM_RST_EN_BIT      = 5;
    localparam int          DCM_R_LSB           = 0;
    localparam int          DCM_R_W             = 5;
    localparam int          RUN_BIT             = 0;
    localparam logic [7:0]  COEF_CTRL_RST       = 8'h00;
    localparam logic [7:0]  DCM_CTRL_RST        = 8'h00;
    localparam logic [4:0]  DCM_LEN_RST         = 5'h01;
    localparam logic [4:0]  DCM_LEN_MIN         = 5'h01;
    localparam logic [4:0]  DCM_LEN_MAX         = 5'h14;
    localparam logic [7:0]  DIV_RST             = 8'h01;
    localparam logic [7:0]  DIV_MAX             = 8'h80;
endpackage

// >>> acs_avg_reset_timer.sv
// Periodic averaging-filter clear timer on the modulator clock tick
`timescale 1ns/10ps
module acs_avg_reset_timer #(
    parameter int CNT_W = 32
) (
    input  wire logic       clock,
    input  wire logic       reset_n,
    input  wire logic       modTick,
    input  wire logic       enable,
    input  wire logic [4:0] exponent,
    output logic            clearPulse
);
    logic [CNT_W-1:0] count_q;
    logic [CNT_W-1:0] count_d;
    logic [CNT_W-1:0] limit;
    wire              wrap = modTick && (count_q >= limit);

    assign limit   = (CNT_W'(1) << exponent) - CNT_W'(1);
    assign count_d = !enable ? '0 : (wrap ? '0 : (modTick ? count_q + CNT_W'(1) : count_q));

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            count_q    <= '0;
            clearPulse <= 1'b0;
        end else begin
            count_q    <= count_d;
            clearPulse <= enable && wrap;
        end
    end

    gated_off_a: assert property (@(posedge clock) disable iff (!reset_n)
        !$past(enable) |-> !clearPulse) else $error("Clear while periodic reset disabled");
endmodule

// >>> acs_ctrl.sv
// APB register bank: coefficient double buffer, swap control and DC-average reset control
`timescale 1ns/10ps
// Notes on behaviour
// - With reset enable set, clear the averaging filter every 2^R modulator cycles.
// - With reset enable clear, never clear the averaging filter.
// - Coefficient access is blocked while running unless adaptive mode is on.
// - Adaptive-mode bit two enables coefficient double buffering.
// - Every coefficient is held in two copies, buffer A and buffer B.
// - Swap request while running in adaptive mode swaps at next sample start.
// - Swap request bit clears itself once the swap happens.
// - In-use flag toggles per swap: 0 means A, 1 means B.
// - While running, coefficient writes go to the buffer not in use.
// - N and M dividers each accept 1 to 128 independently.
// - Averaging length D is programmable from 1 to 20.
module acs_ctrl #(
    parameter int COEF_N = 64,
    parameter int COEF_W = 24
) (
    input  wire logic              clock,
    input  wire logic              reset_n,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [11:0]       paddr,
    input  wire logic [31:0]       pwdata,
    output logic                   pready,
    output logic [31:0]            prdata,
    output logic                   pslverr,
    input  wire logic              modTick,
    input  wire logic              sampleStart,
    input  wire logic [$clog2(COEF_N)-1:0] engineIdx,
    output logic [COEF_W-1:0]      engineCoef,
    output logic                   avgClear,
    output logic [4:0]             avgLength,
    output logic [7:0]             recordDividerN,
    output logic [7:0]             recordDividerM,
    output logic                   converterRun,
    output logic                   bufferInUse
);
    localparam int IW = $clog2(COEF_N);

    logic [COEF_W-1:0] bufA [COEF_N];
    logic [COEF_W-1:0] bufB [COEF_N];
    logic              adapt_q;
    logic              swapReq_q;
    logic              inUse_q;
    logic              rstEn_q;
    logic [4:0]        rExp_q;
    logic [7:0]        latch_q;
    logic [4:0]        avgLen_q;
    logic [7:0]        divN_q;
    logic [7:0]        divM_q;
    logic              run_q;
    logic              ready_q;
    logic [31:0]       rdata_q;
    logic              err_q;
    logic [COEF_W-1:0] coef_q;

    // Setup phase answers in the following access cycle: no wait states on any transfer
    wire        setup      = psel && !penable;
    wire        accessDone = psel && penable && ready_q;
    wire        wrDone     = accessDone && pwrite;
    wire        selCoefCtl = paddr == acs_pkg::COEF_CTRL_ADDR;
    wire        selDcm     = paddr == acs_pkg::DCM_CTRL_ADDR;
    wire        selRun     = paddr == acs_pkg::RUN_CTRL_ADDR;
    wire        selDiv     = paddr == acs_pkg::DIV_CTRL_ADDR;
    wire        selLen     = paddr == acs_pkg::DCM_LEN_ADDR;
    wire        inCoefWin  = paddr[11] && (paddr[1:0] == 2'h0);
    wire [IW:0] coefIdxW   = paddr[IW+2:2];
    wire        coefInRng  = inCoefWin && (int'(coefIdxW[IW-1:0]) < COEF_N) && (paddr[10:IW+3] == '0);
    wire        addrBuf    = coefIdxW[IW] ;
    wire        coefLocked = run_q && !adapt_q;
    wire        selCoef    = coefInRng && !coefLocked;
    wire        mapped     = selCoefCtl || selDcm || selRun || selDiv || selLen || selCoef;
    // Running: target the idle buffer whatever was addressed; stopped: the addressed one
    wire        tgtBuf     = run_q ? !inUse_q : addrBuf;
    wire [IW-1:0] cIdx     = coefIdxW[IW-1:0];
    wire        wrCoefCtl  = wrDone && selCoefCtl;
    wire        wrDcm      = wrDone && selDcm;
    wire        wrRun      = wrDone && selRun;
    wire        wrDiv      = wrDone && selDiv;
    wire        wrLen      = wrDone && selLen;
    wire        wrBufA     = wrDone && selCoef && !tgtBuf;
    wire        wrBufB     = wrDone && selCoef && tgtBuf;
    wire        swapGo     = swapReq_q && sampleStart && run_q && adapt_q;
    wire        swapWrite  = wrDone && selCoefCtl && pwdata[acs_pkg::COEF_SWAP_BIT];
    wire [7:0]  divNwr     = (pwdata[7:0] == 8'h00 || pwdata[7:0] > acs_pkg::DIV_MAX) ? divN_q : pwdata[7:0];
    wire [7:0]  divMwr     = (pwdata[15:8] == 8'h00 || pwdata[15:8] > acs_pkg::DIV_MAX) ? divM_q : pwdata[15:8];
    wire [4:0]  lenWr      = (pwdata[4:0] < acs_pkg::DCM_LEN_MIN || pwdata[4:0] > acs_pkg::DCM_LEN_MAX)
                             ? avgLen_q : pwdata[4:0];
    wire [7:0]  coefCtlRd  = {4'h0, 1'b0, adapt_q, inUse_q, swapReq_q};
    wire [7:0]  dcmRd      = {latch_q[7:6], rstEn_q, rExp_q};
    wire [COEF_W-1:0] coefRd = (addrBuf ? bufB[cIdx] : bufA[cIdx]);
    wire [31:0] rdMux      = selCoefCtl ? {24'h0, coefCtlRd} :
                             selDcm     ? {24'h0, dcmRd} :
                             selRun     ? {31'h0, run_q} :
                             selDiv     ? {16'h0, divM_q, divN_q} :
                             selLen     ? {27'h0, avgLen_q} :
                             selCoef    ? 32'(coefRd) : 32'h0;

    // Bus handshake
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            ready_q <= 1'b0;
            rdata_q <= 32'h0;
            err_q   <= 1'b0;
        end else begin
            ready_q <= setup;
            rdata_q <= (setup && !pwrite) ? rdMux : rdata_q;
            err_q   <= setup && !mapped;
        end
    end

    // Control registers, one short block per register
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            adapt_q <= 1'b0;
        end else if (wrCoefCtl) begin
            adapt_q <= pwdata[acs_pkg::COEF_ADAPT_BIT];
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            latch_q <= acs_pkg::DCM_CTRL_RST;
            rstEn_q <= 1'b0;
            rExp_q  <= 5'h00;
        end else if (wrDcm) begin
            latch_q <= {pwdata[7:6], 6'h00};
            rstEn_q <= pwdata[acs_pkg::DCM_RST_EN_BIT];
            rExp_q  <= pwdata[acs_pkg::DCM_R_LSB +: acs_pkg::DCM_R_W];
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            run_q <= 1'b0;
        end else if (wrRun) begin
            run_q <= pwdata[acs_pkg::RUN_BIT];
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            divN_q <= acs_pkg::DIV_RST;
            divM_q <= acs_pkg::DIV_RST;
        end else if (wrDiv) begin
            divN_q <= divNwr;
            divM_q <= divMwr;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            avgLen_q <= acs_pkg::DCM_LEN_RST;
        end else if (wrLen) begin
            avgLen_q <= lenWr;
        end
    end

    // Swap request and in-use flag; a new request in the swap cycle wins over the clear
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            swapReq_q <= 1'b0;
            inUse_q   <= 1'b0;
        end else begin
            if (swapWrite) begin
                swapReq_q <= 1'b1;
            end else if (swapGo) begin
                swapReq_q <= 1'b0;
            end
            if (swapGo) begin
                inUse_q <= !inUse_q;
            end
        end
    end

    // Coefficient store; no reset so it maps onto plain memory
    always_ff @(posedge clock) begin
        if (wrBufA) begin
            bufA[cIdx] <= pwdata[COEF_W-1:0];
        end
        if (wrBufB) begin
            bufB[cIdx] <= pwdata[COEF_W-1:0];
        end
    end

    // Engine read port follows the buffer in use
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            coef_q <= '0;
        end else begin
            coef_q <= inUse_q ? bufB[engineIdx] : bufA[engineIdx];
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            avgLength      <= acs_pkg::DCM_LEN_RST;
            recordDividerN <= acs_pkg::DIV_RST;
            recordDividerM <= acs_pkg::DIV_RST;
            converterRun   <= 1'b0;
            bufferInUse    <= 1'b0;
        end else begin
            avgLength      <= avgLen_q;
            recordDividerN <= divN_q;
            recordDividerM <= divM_q;
            converterRun   <= run_q;
            bufferInUse    <= inUse_q;
        end
    end

    assign pready     = ready_q;
    assign prdata     = rdata_q;
    assign pslverr    = err_q;
    assign engineCoef = coef_q;

    acs_avg_reset_timer #(
        .CNT_W (32)
    ) u_timer (
        .clock      (clock),
        .reset_n    (reset_n),
        .modTick    (modTick),
        .enable     (rstEn_q),
        .exponent   (rExp_q),
        .clearPulse (avgClear)
    );

    sequence swapArmed_s;
        swapReq_q && run_q && adapt_q && sampleStart;
    endsequence

    swap_toggle_a: assert property (@(posedge clock) disable iff (!reset_n)
        swapArmed_s |=> (inUse_q != $past(inUse_q))) else $error("In-use flag did not toggle");
    swap_clear_a: assert property (@(posedge clock) disable iff (!reset_n)
        (swapArmed_s and !swapWrite) |=> !swapReq_q) else $error("Swap request not cleared");
    swap_idle_a: assert property (@(posedge clock) disable iff (!reset_n)
        !(run_q && adapt_q) |=> $stable(inUse_q)) else $error("Swap while not allowed");
    swap_wait_a: assert property (@(posedge clock) disable iff (!reset_n)
        !sampleStart |=> $stable(inUse_q)) else $error("Swap outside sample start");
    lock_err_a: assert property (@(posedge clock) disable iff (!reset_n)
        setup && coefInRng && run_q && !adapt_q |=> pslverr) else $error("Locked coefficient not refused");
    div_range_a: assert property (@(posedge clock) disable iff (!reset_n)
        divN_q != 8'h00 && divN_q <= acs_pkg::DIV_MAX && divM_q != 8'h00 && divM_q <= acs_pkg::DIV_MAX)
        else $error("Divider out of range");
    len_range_a: assert property (@(posedge clock) disable iff (!reset_n)
        avgLen_q >= acs_pkg::DCM_LEN_MIN && avgLen_q <= acs_pkg::DCM_LEN_MAX)
        else $error("Averaging length out of range");
    adapt_set_a: assert property (@(posedge clock) disable iff (!reset_n)
        wrDone && selCoefCtl |=> adapt_q == $past(pwdata[acs_pkg::COEF_ADAPT_BIT]))
        else $error("Adaptive bit not stored");
    redirect_a: assert property (@(posedge clock) disable iff (!reset_n)
        wrDone && selCoef && run_q |-> tgtBuf == !inUse_q) else $error("Running write not redirected");
    stopped_a: assert property (@(posedge clock) disable iff (!reset_n)
        wrDone && selCoef && !run_q |-> tgtBuf == addrBuf) else $error("Stopped write misdirected");
    pulse_a: assert property (@(posedge clock) disable iff (!reset_n)
        avgClear |=> !avgClear) else $error("Clear pulse longer than one cycle");

    // Bus answer: no wait state, one-cycle ready, read data held between reads
    ready_next_a: assert property (@(posedge clock) disable iff (!reset_n)
        setup |=> pready)
        else $error("No ready after setup");
    ready_pulse_a: assert property (@(posedge clock) disable iff (!reset_n)
        pready |=> !pready)
        else $error("Ready longer than one cycle");
    rdata_hold_a: assert property (@(posedge clock) disable iff (!reset_n)
        !(setup && !pwrite) |=> $stable(prdata))
        else $error("Read data changed without a read");
    err_map_a: assert property (@(posedge clock) disable iff (!reset_n)
        setup && !mapped |=> pslverr)
        else $error("Unmapped access not refused");
    err_clear_a: assert property (@(posedge clock) disable iff (!reset_n)
        setup && mapped |=> !pslverr)
        else $error("Mapped access refused");

    // Register stores and their output copies
    run_store_a: assert property (@(posedge clock) disable iff (!reset_n)
        wrRun |=> run_q == $past(pwdata[acs_pkg::RUN_BIT]))
        else $error("Run bit not stored");
    run_hold_a: assert property (@(posedge clock) disable iff (!reset_n)
        !wrRun |=> $stable(run_q))
        else $error("Run bit changed without a write");
    run_out_a: assert property (@(posedge clock) disable iff (!reset_n)
        1'b1 |=> converterRun == $past(run_q))
        else $error("Run output not following");
    adapt_hold_a: assert property (@(posedge clock) disable iff (!reset_n)
        !wrCoefCtl |=> $stable(adapt_q))
        else $error("Adaptive bit changed without a write");
    rst_en_store_a: assert property (@(posedge clock) disable iff (!reset_n)
        wrDcm |=> rstEn_q == $past(pwdata[acs_pkg::DCM_RST_EN_BIT]))
        else $error("Reset enable not stored");
    rexp_store_a: assert property (@(posedge clock) disable iff (!reset_n)
        wrDcm |=> rExp_q == $past(pwdata[4:0]))
        else $error("Reset exponent not stored");
    clear_tick_a: assert property (@(posedge clock) disable iff (!reset_n)
        avgClear |-> $past(modTick))
        else $error("Clear without modulator tick");
    clear_off_a: assert property (@(posedge clock) disable iff (!reset_n)
        !rstEn_q |=> !avgClear)
        else $error("Clear while reset enable off");
    divn_take_a: assert property (@(posedge clock) disable iff (!reset_n)
        wrDiv && pwdata[7:0] != 8'h00 && pwdata[7:0] <= acs_pkg::DIV_MAX |=> divN_q == $past(pwdata[7:0]))
        else $error("Legal N divider not taken");
    divn_keep_a: assert property (@(posedge clock) disable iff (!reset_n)
        wrDiv && (pwdata[7:0] == 8'h00 || pwdata[7:0] > acs_pkg::DIV_MAX) |=> $stable(divN_q))
        else $error("Illegal N divider taken");
    divm_take_a: assert property (@(posedge clock) disable iff (!reset_n)
        wrDiv && pwdata[15:8] != 8'h00 && pwdata[15:8] <= acs_pkg::DIV_MAX |=> divM_q == $past(pwdata[15:8]))
        else $error("Legal M divider not taken");
    divm_keep_a: assert property (@(posedge clock) disable iff (!reset_n)
        wrDiv && (pwdata[15:8] == 8'h00 || pwdata[15:8] > acs_pkg::DIV_MAX) |=> $stable(divM_q))
        else $error("Illegal M divider taken");
    len_take_a: assert property (@(posedge clock) disable iff (!reset_n)
        wrLen && pwdata[4:0] >= acs_pkg::DCM_LEN_MIN && pwdata[4:0] <= acs_pkg::DCM_LEN_MAX
        |=> avgLen_q == $past(pwdata[4:0])) else $error("Legal length not taken");
    len_keep_a: assert property (@(posedge clock) disable iff (!reset_n)
        wrLen && (pwdata[4:0] < acs_pkg::DCM_LEN_MIN || pwdata[4:0] > acs_pkg::DCM_LEN_MAX) |=> $stable(avgLen_q))
        else $error("Illegal length taken");

    // Coefficient store
    bufa_write_a: assert property (@(posedge clock) disable iff (!reset_n)
        wrBufA |=> bufA[$past(cIdx)] == $past(pwdata[COEF_W-1:0]))
        else $error("Buffer A write lost");
    bufb_write_a: assert property (@(posedge clock) disable iff (!reset_n)
        wrBufB |=> bufB[$past(cIdx)] == $past(pwdata[COEF_W-1:0]))
        else $error("Buffer B write lost");
    lock_keep_a: assert property (@(posedge clock) disable iff (!reset_n)
        wrDone && coefInRng && coefLocked
        |=> bufA[$past(cIdx)] == $past(bufA[cIdx]) && bufB[$past(cIdx)] == $past(bufB[cIdx]))
        else $error("Locked coefficient written");

    // Swap request life cycle
    sequence swapPend_s;
        swapReq_q && !(run_q && adapt_q);
    endsequence

    req_set_a: assert property (@(posedge clock) disable iff (!reset_n)
        swapWrite |=> swapReq_q)
        else $error("Swap request not taken");
    req_hold_a: assert property (@(posedge clock) disable iff (!reset_n)
        swapReq_q && !sampleStart |=> swapReq_q)
        else $error("Swap request cleared early");
    pend_hold_a: assert property (@(posedge clock) disable iff (!reset_n)
        swapPend_s |=> swapReq_q)
        else $error("Pending swap request lost");
    inuse_out_a: assert property (@(posedge clock) disable iff (!reset_n)
        1'b1 |=> bufferInUse == $past(inUse_q))
        else $error("In-use output not following");
endmodule

// >>> acs_engine_model.sv
// Filter engine side model: modulator tick and sample period start pulses
`timescale 1ns/10ps
module acs_engine_model (
    input  wire logic clock,
    input  wire logic reset_n,
    output logic      modTick,
    output logic      sampleStart
);
    logic [4:0] phase_q;
    logic [4:0] phase_d;

    assign phase_d = phase_q + 5'h01;
    // Fixed ratio keeps clear counts exact: tick every 4 clocks, sample every 32
    assign modTick     = (phase_q[1:0] == 2'h3);
    assign sampleStart = (phase_q == 5'h1f);

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            phase_q <= 5'h00;
        end else begin
            phase_q <= phase_d;
        end
    end
endmodule

// >>> tb.sv
// Self-checking bench for the record control register bank
`timescale 1ns/10ps
module tb;
    localparam logic [11:0] A3 = acs_pkg::COEF_BASE_ADDR + 12'h00c;
    localparam logic [11:0] B3 = acs_pkg::COEF_BASE_ADDR + 12'h10c;
    logic        clock = 1'b0;
    logic        reset_n = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [5:0]  engineIdx = 6'h03;
    logic        pready, pslverr, modTick, sampleStart, avgClear, converterRun, bufferInUse;
    logic [31:0] prdata, rdata;
    logic        rerr;
    logic [23:0] engineCoef;
    logic [4:0]  avgLength;
    logic [7:0]  recordDividerN, recordDividerM;
    int          errors = 0;
    int          checks = 0;
    int          cycles = 0;
    int          clears = 0;

    acs_engine_model eng (.clock(clock), .reset_n(reset_n), .modTick(modTick), .sampleStart(sampleStart));
    acs_ctrl dut (.clock(clock), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .modTick(modTick), .sampleStart(sampleStart), .engineIdx(engineIdx), .engineCoef(engineCoef),
        .avgClear(avgClear), .avgLength(avgLength), .recordDividerN(recordDividerN),
        .recordDividerM(recordDividerM), .converterRun(converterRun), .bufferInUse(bufferInUse));

    always #5 clock = ~clock;

    always @(posedge clock) begin
        cycles++;
        if (avgClear === 1'b1) begin
            clears++;
        end
        // Whole run needs under 2000 cycles
        if (cycles == 5000) begin
            errors++;
            report_and_stop();
        end
    end

    task automatic report_and_stop();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("mismatch %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clock);
    endtask

    // Setup, then access held until pready is seen high at a rising edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 20);
        chk(n < 20, 1'b1, "no pready");
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp, input logic err);
        apb(1'b0, a, 32'h0);
        chk(rdata, exp, "read data");
        chk(rerr, err, "response");
    endtask

    task automatic t_reset();
        tick(1);
        chk({avgLength, recordDividerN, recordDividerM}, {5'h01, 8'h01, 8'h01}, "reset fields");
        chk({converterRun, bufferInUse, engineCoef}, 32'h0, "reset state");
        rdchk(acs_pkg::DCM_CTRL_ADDR, 32'h0, 1'b0);
        rdchk(12'h100, 32'h0, 1'b1);
    endtask

    task automatic t_limits();
        // Outputs are one register behind the stored value: look two edges after the write
        apb(1'b1, acs_pkg::DIV_CTRL_ADDR, 32'h8080);
        tick(2);
        chk({recordDividerM, recordDividerN}, 16'h8080, "divider max");
        apb(1'b1, acs_pkg::DIV_CTRL_ADDR, 32'h0);
        tick(2);
        chk({recordDividerM, recordDividerN}, 16'h8080, "divider zero kept");
        apb(1'b1, acs_pkg::DCM_LEN_ADDR, 32'h14);
        tick(2);
        chk(avgLength, 5'h14, "length max");
        apb(1'b1, acs_pkg::DCM_LEN_ADDR, 32'h15);
        tick(2);
        chk(avgLength, 5'h14, "length over kept");
        apb(1'b1, acs_pkg::DCM_LEN_ADDR, 32'h01);
        // Filter A at oversampling 128: M*128/32 = 16 stays above class 8
        apb(1'b1, acs_pkg::DIV_CTRL_ADDR, 32'h0402);
        tick(2);
        chk({recordDividerM, recordDividerN}, 16'h0402, "recommended dividers");
    endtask

    task automatic t_avg();
        int c0;
        apb(1'b1, acs_pkg::DCM_CTRL_ADDR, 32'h22);
        tick(40);
        c0 = clears;
        tick(160);
        chk(clears - c0, 32'd10, "clear period");
        apb(1'b1, acs_pkg::DCM_CTRL_ADDR, 32'h02);
        tick(4);
        c0 = clears;
        tick(160);
        chk(clears - c0, 32'd0, "clear disabled");
    endtask

    task automatic t_coef();
        apb(1'b1, A3, 32'h111);
        apb(1'b1, B3, 32'h222);
        rdchk(A3, 32'h111, 1'b0);
        rdchk(B3, 32'h222, 1'b0);
        chk(engineCoef, 24'h111, "engine from A");
        apb(1'b1, acs_pkg::RUN_CTRL_ADDR, 32'h1);
        tick(2);
        chk(converterRun, 1'b1, "running");
        rdchk(A3, 32'h0, 1'b1);
        apb(1'b1, A3, 32'h999);
        chk(rerr, 1'b1, "locked write refused");
        apb(1'b1, acs_pkg::COEF_CTRL_ADDR, 32'h4);
        apb(1'b1, A3, 32'h333);
        rdchk(B3, 32'h333, 1'b0);
        rdchk(A3, 32'h111, 1'b0);
        apb(1'b1, acs_pkg::COEF_CTRL_ADDR, 32'h5);
        tick(40);
        apb(1'b0, acs_pkg::COEF_CTRL_ADDR, 32'h0);
        chk(rdata[2:0], 3'b110, "swap done");
        chk(bufferInUse, 1'b1, "in use B");
        chk(engineCoef, 24'h333, "engine from B");
        apb(1'b1, B3, 32'h444);
        rdchk(A3, 32'h444, 1'b0);
        apb(1'b1, acs_pkg::COEF_CTRL_ADDR, 32'h1);
        tick(40);
        chk(bufferInUse, 1'b1, "swap ignored");
    endtask

    initial begin
        repeat (5) @(posedge clock);
        reset_n <= 1'b1;
        t_reset();
        t_limits();
        t_avg();
        t_coef();
        report_and_stop();
    end
endmodule
